// >>> src/flash_spm_seq.sv
// Flash self-program sequencer: control register, arm window, page ops.
// Assumes the core pulses store_instr/load_instr and honours core_halt.
`timescale 1ns/1ps
module flash_spm_seq
  import flash_spm_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic store_instr,
  input wire logic load_instr,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [7:0] pointer_high_byte,
  input wire logic [15:0] store_data,
  input wire logic eeprom_write,
  output logic core_halt,
  output logic store_ready_irq,
  output logic flash_erase,
  output logic flash_program,
  output logic [PAGE_BITS-1:0] flash_page,
  output logic [WORD_BITS-1:0] buf_word_idx,
  output logic [16:0] load_byte_addr,
  output logic lock_write,
  output logic [7:0] lock_data
);
  logic [4:0] cmd_r, cmd_nxt;
  logic irq_en_r, irq_en_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] ext_r, ext_nxt;
  logic [9:0] section_r, section_nxt;
  seq_state_e state_r, state_nxt;
  logic [2:0] arm_cnt_r, arm_cnt_nxt;
  logic [31:0] prog_cnt_r, prog_cnt_nxt;
  logic [PAGE_BITS-1:0] page_r, page_nxt;
  logic halt_r, halt_nxt;
  logic irq_r, irq_nxt;
  logic erase_r, erase_nxt;
  logic program_r, program_nxt;
  logic [16:0] lpm_addr_r, lpm_addr_nxt;
  logic lock_wr_r, lock_wr_nxt;
  logic [7:0] lock_data_r, lock_data_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [WORD_BITS-1:0] rd_idx_r, rd_idx_nxt;
  logic buf_clear;
  logic buf_load;
  logic [16:0] z_addr;
  logic [PAGE_BITS-1:0] z_page;
  logic [WORD_BITS-1:0] z_word;
  logic cmd_ok;
  logic ctl_wr;
  logic fire;
  logic no_read_while_write_section_page;

  // Full 17-bit pointer; bit 0 dropped for stores, word then split.
  assign z_addr = {ext_r[0], pointer_high_byte, pointer_low_byte};
  assign z_word = z_addr[WORD_BITS:1];
  assign z_page = z_addr[16:WORD_BITS+1];
  assign no_read_while_write_section_page = {1'b0, z_page} >= section_r;
  assign ctl_wr = reg_wr && reg_addr == ADDR_CONTROL;
  assign fire = state_r == ST_ARMED && store_instr;

  // Accept only the five legal patterns; others leave the command field alone, though bit 7 is still written.
  always_comb begin
    case (reg_wdata[4:0])
      CMD_LOCK, CMD_REENABLE, CMD_WRITE, CMD_ERASE, CMD_LOAD: begin
        cmd_ok = 1'b1;
      end
      default: begin
        cmd_ok = 1'b0;
      end
    endcase
  end

  // Sequencer: arm window, single-shot store actions, timed page ops.
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    arm_cnt_nxt = arm_cnt_r;
    prog_cnt_nxt = prog_cnt_r;
    page_nxt = page_r;
    halt_nxt = 1'b0;
    erase_nxt = 1'b0;
    program_nxt = 1'b0;
    lock_wr_nxt = 1'b0;
    lock_data_nxt = lock_data_r;
    busy_nxt = busy_r;
    buf_clear = 1'b0;
    buf_load = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (ctl_wr && cmd_ok) begin
          cmd_nxt = reg_wdata[4:0];
          arm_cnt_nxt = 3'(ARM_CYCLES - 1);
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (store_instr) begin
          cmd_nxt = 5'h00;
          state_nxt = ST_IDLE;
          case (cmd_r)
            CMD_LOAD: begin
              buf_load = 1'b1;
              busy_nxt = 1'b0;
            end
            CMD_REENABLE: begin
              buf_clear = 1'b1;
              busy_nxt = 1'b0;
            end
            CMD_LOCK: begin
              lock_wr_nxt = 1'b1;
              lock_data_nxt = store_data[7:0];
            end
            CMD_ERASE, CMD_WRITE: begin
              cmd_nxt = cmd_r;
              page_nxt = z_page;
              prog_cnt_nxt = 32'(PROG_COUNT - 1);
              erase_nxt = cmd_r == CMD_ERASE;
              program_nxt = cmd_r == CMD_WRITE;
              halt_nxt = no_read_while_write_section_page;
              busy_nxt = busy_r | !no_read_while_write_section_page;
              state_nxt = ST_PROG;
            end
            default: begin
              state_nxt = ST_IDLE;
            end
          endcase
        end else if (arm_cnt_r == 3'h0) begin
          cmd_nxt = 5'h00;
          state_nxt = ST_IDLE;
        end else begin
          arm_cnt_nxt = arm_cnt_r - 3'h1;
        end
      end
      ST_PROG: begin
        halt_nxt = halt_r;
        erase_nxt = erase_r;
        program_nxt = program_r;
        if (prog_cnt_r == 32'h0) begin
          halt_nxt = 1'b0;
          erase_nxt = 1'b0;
          program_nxt = 1'b0;
          buf_clear = cmd_r == CMD_WRITE;
          cmd_nxt = 5'h00;
          state_nxt = ST_IDLE;
        end else begin
          prog_cnt_nxt = prog_cnt_r - 32'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cmd_nxt = 5'h00;
      end
    endcase
    if (eeprom_write && state_r != ST_PROG) begin
      buf_clear = 1'b1;
    end
  end

  // Software-only fields and the ready request, which follows enable low.
  always_comb begin
    irq_en_nxt = irq_en_r;
    ext_nxt = ext_r;
    section_nxt = section_r;
    if (ctl_wr) begin
      irq_en_nxt = reg_wdata[BIT_IRQ_EN];
    end
    if (reg_wr && reg_addr == ADDR_EXTENSION) begin
      ext_nxt = {7'h00, reg_wdata[0]};
    end
    if (reg_wr && reg_addr == ADDR_SECTION) begin
      section_nxt = {reg_wdata, 2'b00};
    end
    irq_nxt = irq_en_nxt && !cmd_nxt[0];
  end

  // Byte address for load instructions keeps bit zero as byte select.
  always_comb begin
    lpm_addr_nxt = lpm_addr_r;
    if (load_instr) begin
      lpm_addr_nxt = z_addr;
    end
    rd_idx_nxt = z_word;
  end

  // Read data stands one cycle after the strobe; unmapped reads zero.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONTROL: begin
          rdata_nxt = {irq_en_r, busy_r, 1'b0, cmd_r};
        end
        ADDR_EXTENSION: begin
          rdata_nxt = ext_r;
        end
        ADDR_SECTION: begin
          rdata_nxt = section_r[9:2];
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cmd_r <= CONTROL_RESET[4:0];
      arm_cnt_r <= 3'h0;
      prog_cnt_r <= 32'h0;
      page_r <= '0;
      halt_r <= 1'b0;
      erase_r <= 1'b0;
      program_r <= 1'b0;
      lock_wr_r <= 1'b0;
      lock_data_r <= 8'h00;
      busy_r <= 1'b0;
      irq_en_r <= 1'b0;
      ext_r <= EXTENSION_RESET;
      section_r <= SECTION_RESET;
      irq_r <= 1'b0;
      lpm_addr_r <= 17'h00000;
      rd_idx_r <= '0;
      rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      arm_cnt_r <= arm_cnt_nxt;
      prog_cnt_r <= prog_cnt_nxt;
      page_r <= page_nxt;
      halt_r <= halt_nxt;
      erase_r <= erase_nxt;
      program_r <= program_nxt;
      lock_wr_r <= lock_wr_nxt;
      lock_data_r <= lock_data_nxt;
      busy_r <= busy_nxt;
      irq_en_r <= irq_en_nxt;
      ext_r <= ext_nxt;
      section_r <= section_nxt;
      irq_r <= irq_nxt;
      lpm_addr_r <= lpm_addr_nxt;
      rd_idx_r <= rd_idx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // The buffer read port is indexed by rd_idx_r from the Z pointer in every state; read_data and read_valid are left open.
  page_buffer u_buf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(buf_clear),
    .load(buf_load),
    .load_idx(z_word),
    .load_data(store_data),
    .read_idx(rd_idx_r),
    .read_data(),
    .read_valid()
  );

  assign reg_rdata = rdata_r;
  assign core_halt = halt_r;
  assign store_ready_irq = irq_r;
  assign flash_erase = erase_r;
  assign flash_program = program_r;
  assign flash_page = page_r;
  assign buf_word_idx = rd_idx_r;
  assign load_byte_addr = lpm_addr_r;
  assign lock_write = lock_wr_r;
  assign lock_data = lock_data_r;

  // Window lasts exactly four cycles without a store.
  a_arm_window: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_r == ST_IDLE ##1 (state_r == ST_ARMED && !store_instr) [*4]
    |=> state_r == ST_IDLE && cmd_r == 5'h00)
    else $error("arm window not four cycles");

  a_enable_auto: assert property (@(posedge core_clk) disable iff (!reset_n)
    fire && (cmd_r == CMD_LOAD || cmd_r == CMD_LOCK) |=> !cmd_r[0])
    else $error("enable not cleared after store");

  a_enable_held: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_r == ST_PROG && prog_cnt_r != 32'h0 |=> cmd_r[0])
    else $error("enable dropped during operation");

  a_bad_pattern: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctl_wr && !cmd_ok && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("illegal pattern took effect");

  a_page_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_r == ST_PROG ##1 state_r == ST_PROG
    |-> $stable(flash_page))
    else $error("page changed mid operation");

  a_halt_no_read_while_write_section: assert property (@(posedge core_clk) disable iff (!reset_n)
    fire && (cmd_r == CMD_ERASE || cmd_r == CMD_WRITE)
    |=> core_halt == $past(no_read_while_write_section_page))
    else $error("halt does not follow section");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    irq_en_r && !cmd_r[0] ##1 irq_en_r && !cmd_r[0]
    |-> store_ready_irq)
    else $error("ready request missing");

  a_busy_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    fire && cmd_r == CMD_LOAD |=> !busy_r)
    else $error("busy not cleared by load");

  a_lpm_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
    load_instr |=> load_byte_addr[0] == $past(pointer_low_byte[0]))
    else $error("byte select lost");
endmodule : flash_spm_seq

// >>> src/flash_spm_pkg.sv
// Constants and types for the flash self-program sequencer.
// Assumes a single 20 MHz core clock and a plain register port.
package flash_spm_pkg;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_EXTENSION = 2'h1;
  localparam logic [1:0] ADDR_SECTION = 2'h2;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_LOCK = 3;
  localparam int BIT_REENABLE = 4;
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] EXTENSION_RESET = 8'h00;
  localparam logic [9:0] SECTION_RESET = 10'h3C0;
  localparam int ARM_CYCLES = 4;
  localparam int WORD_BITS = 7;
  localparam int PAGE_BITS = 9;
  localparam int PAGE_WORDS = 128;
  localparam int CLK_MHZ = 20;
  localparam int PROG_TIME_US = 3700;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG = 2'b10
  } seq_state_e;
endpackage : flash_spm_pkg

// >>> src/page_buffer.sv
// Temporary page buffer with per-word valid bits.
// Assumes one load per word between clears; clear wins over a load.
`timescale 1ns/1ps
module page_buffer
  import flash_spm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic load,
  input wire logic [WORD_BITS-1:0] load_idx,
  input wire logic [15:0] load_data,
  input wire logic [WORD_BITS-1:0] read_idx,
  output logic [15:0] read_data,
  output logic read_valid
);
  logic [15:0] mem_r [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] valid_r;
  logic [PAGE_WORDS-1:0] valid_nxt;

  // Any word may be loaded in any order; erased words read all ones.
  always_comb begin
    valid_nxt = valid_r;
    if (clear) begin
      valid_nxt = '0;
    end else if (load) begin
      valid_nxt[load_idx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_r <= '0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // Storage needs no reset because the valid bits mask stale data.
  genvar g;
  generate
    for (g = 0; g < PAGE_WORDS; g++) begin : g_word
      always_ff @(posedge core_clk) begin
        if (load && !clear && load_idx == WORD_BITS'(g)) begin
          mem_r[g] <= load_data;
        end
      end
    end
  endgenerate

  assign read_valid = valid_r[read_idx];
  assign read_data = valid_r[read_idx] ? mem_r[read_idx] : 16'hFFFF;
endmodule : page_buffer

// >>> test/core_model.sv
// Processor core model: issues store and load instructions with a Z pointer.
// Assumes each call starts just after a rising core_clk edge.
`timescale 1ns/1ps
module core_model (
  input wire logic core_clk,
  output logic store_instr,
  output logic load_instr,
  output logic [7:0] pointer_low_byte,
  output logic [7:0] pointer_high_byte,
  output logic [15:0] store_data
);
  logic [127:0] used;

  // An idle core issues nothing and points at zero.
  initial begin
    used = '0;
    store_instr = 1'b0;
    load_instr = 1'b0;
    pointer_low_byte = 8'h00;
    pointer_high_byte = 8'h00;
    store_data = 16'h0000;
  end

  // Moves the Z pointer without issuing an instruction.
  task automatic point(input logic [15:0] z);
    {pointer_high_byte, pointer_low_byte} <= z;
  endtask : point

  // A word already loaded is never loaded again before a clear.
  task automatic store(input logic [15:0] z, input logic [15:0] d,
                       input bit ld);
    if (!(ld && used[z[7:1]])) begin
      if (ld) begin
        used[z[7:1]] = 1'b1;
      end
      point(z);
      store_data <= d;
      store_instr <= 1'b1;
      @(posedge core_clk);
      store_instr <= 1'b0;
      store_data <= ~d; // The register pair is reused, so stale data changes.
    end
  endtask : store

  // One load-program instruction at byte address z.
  task automatic load(input logic [15:0] z);
    point(z);
    load_instr <= 1'b1;
    @(posedge core_clk);
    load_instr <= 1'b0;
  endtask : load

  // The buffer has been cleared, so every word may be loaded again.
  task automatic clear_used();
    used = '0;
  endtask : clear_used
endmodule : core_model

// >>> test/test_flash_spm_seq.sv
// Self-checking bench for the flash self-program sequencer.
// Assumes the design package and the core model are compiled first.
`timescale 1ns/1ps
module test_flash_spm_seq;
  import flash_spm_pkg::*;
  localparam int PC = 20;
  logic core_clk, reset_n, reg_wr, reg_rd, eeprom_write;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, lock_data, zh;
  logic store_instr, load_instr, core_halt, store_ready_irq;
  logic flash_erase, flash_program, lock_write, ext0, rd_d, op_d;
  logic [7:0] pointer_low_byte, pointer_high_byte;
  logic [15:0] store_data, z;
  logic [PAGE_BITS-1:0] flash_page;
  logic [WORD_BITS-1:0] buf_word_idx;
  logic [16:0] load_byte_addr;
  logic [7:0] rd_q[$];
  logic [11:0] op_q[$];
  logic [7:0] pats[5] = '{8'h11, 8'h09, 8'h05, 8'h03, 8'h01};
  logic [4:0] v;
  int n_fail = 0, total_checks = 0, op_len = 0;

  flash_spm_seq #(.PROG_COUNT(PC)) DUT (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .store_instr(store_instr), .load_instr(load_instr),
    .pointer_low_byte(pointer_low_byte),
    .pointer_high_byte(pointer_high_byte), .store_data(store_data),
    .eeprom_write(eeprom_write), .core_halt(core_halt),
    .store_ready_irq(store_ready_irq), .flash_erase(flash_erase),
    .flash_program(flash_program), .flash_page(flash_page),
    .buf_word_idx(buf_word_idx), .load_byte_addr(load_byte_addr),
    .lock_write(lock_write), .lock_data(lock_data));
  core_model core (.core_clk(core_clk), .store_instr(store_instr),
    .load_instr(load_instr), .pointer_low_byte(pointer_low_byte),
    .pointer_high_byte(pointer_high_byte), .store_data(store_data));

  // Free-running 20 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic bad(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : bad
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) bad($sformatf("register read %h, want %h", g, e));
  endtask : cmp_reg
  task automatic cmp_op(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) bad($sformatf("page operation %h, want %h", g, e));
  endtask : cmp_op
  task automatic cmp_sig(input logic [16:0] g, input logic [16:0] e);
    total_checks++;
    if (g !== e) bad($sformatf("output level %h, want %h", g, e));
  endtask : cmp_sig
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Register bus master: one strobe cycle, then a released cycle.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd
  // Bounded wait for the running page operation to finish.
  task automatic wait_idle();
    int n;
    n = 0;
    while ((flash_erase | flash_program) !== 1'b0) begin
      @(posedge core_clk);
      n++;
      if (n > 200) begin
        bad("page operation never ended");
        conclude();
      end
    end
    repeat (2) @(posedge core_clk);
  endtask : wait_idle
  // Page operation; the pointer is scrambled at once to prove the latch.
  task automatic page_op(input logic [7:0] cmd, input logic [7:0] during,
                         input logic halt);
    wr(ADDR_CONTROL, cmd);
    op_q.push_back({cmd == 8'h03, cmd == 8'h05, halt, ext0, zh});
    core.store({zh, 8'($urandom)}, 16'($urandom), 1'b0);
    core.point(~{zh, 8'h00});
    rd(ADDR_CONTROL, during);
    wait_idle();
  endtask : page_op

  // Watcher: read data one cycle after the strobe, page operations at start.
  always @(posedge core_clk) begin
    if (rd_d === 1'b1) begin
      if (rd_q.size() == 0) bad("read data with no request");
      else cmp_reg(reg_rdata, rd_q.pop_front());
    end
    rd_d <= reg_rd;
    if ((flash_erase | flash_program) === 1'b1 && op_d !== 1'b1) begin
      op_len = 1;
      if (op_q.size() == 0) bad("page operation not requested");
      else cmp_op({flash_erase, flash_program, core_halt, flash_page},
                  op_q.pop_front());
    end else if ((flash_erase | flash_program) === 1'b1) begin
      op_len++;
    end else if (op_d === 1'b1) begin
      cmp_sig(17'(op_len), 17'(PC));
    end
    op_d <= flash_erase | flash_program;
  end

  initial begin
    reset_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    eeprom_write = 1'b0;
    rd_d = 1'b0;
    op_d = 1'b0;
    void'($urandom(21051));
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_EXTENSION, EXTENSION_RESET);
    rd(ADDR_SECTION, 8'(SECTION_RESET >> 2));
    rd(2'h3, 8'h00);
    $display("test reset values done");
    // Each legal command stands while armed, then clears on timeout.
    foreach (pats[i]) begin
      wr(ADDR_CONTROL, pats[i]);
      rd(ADDR_CONTROL, pats[i]);
      repeat (4) @(posedge core_clk);
      rd(ADDR_CONTROL, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      v = 5'($urandom_range(31, 0));
      while (v inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}) v = v + 5'h02;
      wr(ADDR_CONTROL, {3'b000, v});
      rd(ADDR_CONTROL, 8'h00);
    end
    $display("test command patterns done");
    wr(ADDR_CONTROL, 8'h81);
    @(negedge core_clk);
    cmp_sig(17'(store_ready_irq), 17'h0);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    cmp_sig(17'(store_ready_irq), 17'h1);
    wr(ADDR_CONTROL, 8'h01);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    cmp_sig(17'(store_ready_irq), 17'h0);
    $display("test ready request done");
    // Boundary page 0x100: extension bit set means the protected section.
    wr(ADDR_SECTION, 8'h40);
    rd(ADDR_SECTION, 8'h40);
    wr(ADDR_EXTENSION, 8'h01);
    rd(ADDR_EXTENSION, 8'h01);
    ext0 = 1'b1;
    zh = 8'($urandom);
    // Two loads in falling word order, pointer bit zero random.
    for (int i = 0; i < 2; i++) begin
      z = {zh, 7'(127 - i), 1'($urandom)};
      wr(ADDR_CONTROL, 8'h01);
      core.store(z, 16'($urandom), 1'b1);
      @(posedge core_clk);
      @(negedge core_clk);
      cmp_sig(17'(buf_word_idx), 17'(z[7:1]));
      rd(ADDR_CONTROL, 8'h00);
    end
    eeprom_write <= 1'b1;
    @(posedge core_clk);
    eeprom_write <= 1'b0;
    z = {zh, 8'($urandom) | 8'h01};
    core.load(z);
    @(posedge core_clk);
    @(negedge core_clk);
    cmp_sig(load_byte_addr, {ext0, z});
    $display("test buffer loads done");
    page_op(8'h03, 8'h03, 1'b1);
    rd(ADDR_CONTROL, 8'h00);
    wr(ADDR_EXTENSION, 8'h00);
    ext0 = 1'b0;
    // Erase, load word 0, then write the same page in the open section.
    page_op(8'h03, 8'h43, 1'b0);
    rd(ADDR_CONTROL, 8'h40);
    wr(ADDR_CONTROL, 8'h01);
    core.store({zh, 8'h00}, 16'($urandom), 1'b1);
    rd(ADDR_CONTROL, 8'h00);
    page_op(8'h05, 8'h45, 1'b0);
    core.clear_used();
    rd(ADDR_CONTROL, 8'h40);
    wr(ADDR_CONTROL, 8'h11);
    core.store(16'h0000, 16'h0000, 1'b0);
    rd(ADDR_CONTROL, 8'h00);
    $display("test page operations done");
    wr(ADDR_CONTROL, 8'h09);
    core.store(16'h0001, 16'h00A5, 1'b0);
    for (int n = 0; n < 8 && lock_write !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    cmp_sig({lock_write, 8'h00, lock_data}, {1'b1, 8'h00, 8'hA5});
    rd(ADDR_CONTROL, 8'h00);
    repeat (3) @(posedge core_clk);
    cmp_sig(17'(op_q.size() + rd_q.size()), 17'h0);
    $display("test lock store done");
    conclude();
  end
endmodule : test_flash_spm_seq
